//--- verilog/serial_select_pkg.sv
/*
  Constants, states and state records for the serial port-select command
  receiver. Assumes a 40 MHz system clock and a 19200 bps control line.
*/
package serial_select_pkg;

  // line timing
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_BPS = 19200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYCLES - 1);

  // character framing
  localparam int DATA_BITS = 8;
  localparam logic [2:0] RX_BIT_LAST = 3'h7;
  localparam logic [3:0] TX_BIT_LAST = 4'h9;

  // command codes and channel range
  localparam logic [7:0] CODE_FIRST = 8'h10;
  localparam logic [7:0] CODE_LAST = 8'h1f;
  localparam logic [7:0] CODE_VIDEO_OFF = 8'h71;
  localparam logic [4:0] CHANNEL_OFF = 5'h00;
  localparam logic [4:0] CHANNEL_MAX = 5'h10;
  localparam logic [4:0] CHANNEL_RESET = 5'h00;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_SEND} tx_state_t;

  typedef struct packed {
    rx_state_t state;
    logic [CNT_W-1:0] count;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic valid;
  } rx_reg_t;

  typedef struct packed {
    tx_state_t state;
    logic [CNT_W-1:0] count;
    logic [3:0] bit_idx;
    logic [8:0] frame;
    logic tx_line;
    logic pend_valid;
    logic [7:0] pend_data;
    logic [4:0] channel;
    logic video_on;
  } sel_reg_t;

endpackage : serial_select_pkg

//--- verilog/rx_byte_if.sv
/*
  Carries one received byte and its one-cycle valid strobe from the line
  receiver to the command interpreter. Assumes a single clock domain.
*/
interface rx_byte_if;
  logic [7:0] data;
  logic valid;

  modport src (output data, output valid);
  modport dst (input data, input valid);
endinterface : rx_byte_if

//--- verilog/serial_line_rx.sv
/*
  Asynchronous serial character receiver. Assumes the line input is
  already synchronous to clk_sys and idles high.
*/
module serial_line_rx
  import serial_select_pkg::*;
(
  input logic clk_sys, // system clock
  input logic reset_n, // synchronous reset
  input logic rx_serial, // serial line in
  rx_byte_if.src link // received byte out
);

  rx_reg_t r;
  rx_reg_t next_r;

  // framing state machine, sampling at mid-bit
  always_comb
  begin
    next_r = r;
    next_r.valid = 1'b0;
    case (r.state)
      RX_IDLE:
      begin
        if (!rx_serial) // falling edge opens a frame
        begin
          next_r.state = RX_START;
          next_r.count = HALF_LAST;
        end
      end
      RX_START:
      begin
        if (r.count == '0)
        begin
          if (!rx_serial)
          begin
            next_r.state = RX_DATA;
            next_r.count = BIT_LAST;
            next_r.bit_idx = '0;
          end
          else
            next_r.state = RX_IDLE; // glitch, not a start bit
        end
        else
          next_r.count = r.count - 1'b1;
      end
      RX_DATA:
      begin
        if (r.count == '0)
        begin
          next_r.shift = {rx_serial, r.shift[7:1]}; // lsb first
          next_r.count = BIT_LAST;
          if (r.bit_idx == RX_BIT_LAST) // eight bits, no parity
            next_r.state = RX_STOP;
          else
            next_r.bit_idx = r.bit_idx + 1'b1;
        end
        else
          next_r.count = r.count - 1'b1;
      end
      RX_STOP:
      begin
        if (r.count == '0)
        begin
          next_r.state = RX_IDLE; // ready at once for the next
          next_r.valid = rx_serial; // bad stop bit drops the byte
        end
        else
          next_r.count = r.count - 1'b1;
      end
      default:
        next_r.state = RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      r.state <= RX_IDLE;
      r.count <= '0;
      r.bit_idx <= '0;
      r.shift <= '0;
      r.valid <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign link.data = r.shift;
  assign link.valid = r.valid;

endmodule : serial_line_rx

//--- verilog/serial_port_select.sv
/*
  Serial port-select command interpreter: decodes single-byte commands,
  selects a computer port or video off, echoes valid commands and sends
  the code of a new channel through one pending byte, which a later event
  overwrites if still waiting. Assumes one 40 MHz clock, a line input
  synchronous to it, and a local selection port from the front panel.
*/
module serial_port_select
  import serial_select_pkg::*;
(
  input logic clk_sys, // system clock, 40 MHz
  input logic reset_n, // synchronous reset
  input logic rx_serial, // command line in
  input logic sel_req, // local select pulse
  input logic [4:0] sel_channel, // local channel, 0 to 16
  output logic tx_serial, // command line out
  output logic [4:0] channel, // selected channel, 0 is off
  output logic video_on // a computer port is routed
);

  sel_reg_t r;
  sel_reg_t next_r;
  rx_byte_if rx_link ();

  logic code_ok;
  logic [4:0] code_channel;
  logic local_ok;
  logic [7:0] local_code;

  // line receiver
  serial_line_rx u_rx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rx_serial(rx_serial),
    .link(rx_link)
  );

  // decode a received byte into a channel
  always_comb
  begin
    code_ok = 1'b0;
    code_channel = CHANNEL_OFF;
    if (rx_link.data >= CODE_FIRST && rx_link.data <= CODE_LAST)
    begin
      code_ok = 1'b1;
      code_channel = {1'b0, rx_link.data[3:0]} + 5'h01;
    end
    else if (rx_link.data == CODE_VIDEO_OFF)
      code_ok = 1'b1;
  end

  // local request: in range and a real change
  always_comb
  begin
    local_ok = sel_req && sel_channel <= CHANNEL_MAX
      && sel_channel != r.channel;
    if (sel_channel == CHANNEL_OFF)
      local_code = CODE_VIDEO_OFF;
    else
      local_code = CODE_FIRST + {3'h0, sel_channel} - 8'h01; // 16 is 1f
  end

  // channel update, pending byte and transmitter
  always_comb
  begin
    next_r = r;
    case (r.state)
      TX_IDLE:
      begin
        next_r.tx_line = 1'b1;
        if (r.pend_valid)
        begin
          next_r.state = TX_SEND;
          next_r.frame = {1'b1, r.pend_data}; // stop then data
          next_r.tx_line = 1'b0; // start bit
          next_r.count = BIT_LAST;
          next_r.bit_idx = '0;
          next_r.pend_valid = 1'b0;
        end
      end
      TX_SEND:
      begin
        if (r.count == '0)
        begin
          next_r.count = BIT_LAST;
          if (r.bit_idx == TX_BIT_LAST) // ten bit times done
          begin
            next_r.state = TX_IDLE;
            next_r.tx_line = 1'b1;
          end
          else
          begin
            next_r.tx_line = r.frame[0]; // lsb first
            next_r.frame = {1'b1, r.frame[8:1]};
            next_r.bit_idx = r.bit_idx + 1'b1;
          end
        end
        else
          next_r.count = r.count - 1'b1;
      end
      default:
      begin
        next_r.state = TX_IDLE;
        next_r.tx_line = 1'b1;
      end
    endcase
    // new events come after the load so a fresh byte in the load cycle is not lost
    if (rx_link.valid && code_ok)
    begin
      next_r.channel = code_channel;
      next_r.video_on = code_channel != CHANNEL_OFF;
      next_r.pend_valid = 1'b1; // echo, also the change code
      next_r.pend_data = rx_link.data;
    end
    else if (local_ok && !rx_link.valid)
    begin
      next_r.channel = sel_channel;
      next_r.video_on = sel_channel != CHANNEL_OFF;
      next_r.pend_valid = 1'b1; // announce the new channel
      next_r.pend_data = local_code;
    end
    // anything else received is dropped silently
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      r.state <= TX_IDLE;
      r.count <= '0;
      r.bit_idx <= '0;
      r.frame <= '0;
      r.tx_line <= 1'b1;
      r.pend_valid <= 1'b0;
      r.pend_data <= '0;
      r.channel <= CHANNEL_RESET;
      r.video_on <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign tx_serial = r.tx_line;
  assign channel = r.channel;
  assign video_on = r.video_on;

endmodule : serial_port_select

//--- tb/serial_port_select_sva.sv
/* checker on the top ports of the port-select block
   assumes one clock and a synchronous active-low reset */
module serial_port_select_sva
(
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset
  input wire logic rx_serial, // line in
  input wire logic sel_req, // local pulse
  input wire logic [4:0] sel_channel, // local channel
  input wire logic tx_serial, // line out
  input wire logic [4:0] channel, // channel
  input wire logic video_on // routed
);
  timeunit 1ns;
  timeprecision 1ps;
  // single domain
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // outputs tied to their causes
  video_match_a: assert property (video_on == (channel != 5'h00))
    else $error("video flag wrong");
  chan_range_a: assert property (channel <= 5'h10)
    else $error("channel out of range");
  reset_idle_a: assert property (disable iff (1'b0)
    !reset_n |=> tx_serial && channel == 5'h00) else $error("reset state");
  local_sel_a: assert property (sel_req && sel_channel <= 5'h10
    && sel_channel != channel |=> channel == $past(sel_channel))
    else $error("local select lost");
  bad_sel_a: assert property (sel_req && sel_channel > 5'h10
    |=> $stable(channel)) else $error("bad select taken");
  start_bit_a: assert property ($fell(tx_serial)
    |-> !tx_serial [*8]) else $error("short low bit");
  high_bit_a: assert property ($rose(tx_serial)
    |-> tx_serial [*8]) else $error("short high bit");
  chan_cause_a: assert property ($changed(channel)
    |-> $past(sel_req) || rx_serial) else $error("channel moved alone");
endmodule : serial_port_select_sva

bind serial_port_select serial_port_select_sva u_sva (.clk_sys(clk_sys),
  .reset_n(reset_n), .rx_serial(rx_serial), .sel_req(sel_req),
  .sel_channel(sel_channel), .tx_serial(tx_serial), .channel(channel),
  .video_on(video_on));

//--- tb/serial_host.sv
/* host model: sends command bytes, collects bytes sent back
   assumes line timing from the package */
module serial_host
  import serial_select_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic line_in, // device line out
  output logic line_out // device line in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic [7:0] b;
  initial line_out = 1'b1; // idle high
  // start, lsb first data, stop; one bit time each
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0}; // no parity
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_sys);
      line_out = f[i];
      repeat (BIT_CYCLES - 1) @(negedge clk_sys);
    end
  endtask : send
  // mid-bit sampling, never throttles the device
  always
  begin
    @(negedge line_in);
    repeat (HALF_BIT_CYCLES) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge clk_sys);
      b[i] = line_in;
    end
    repeat (BIT_CYCLES) @(posedge clk_sys);
    got.push_back(b);
  end
endmodule : serial_host

//--- tb/test_serial_port_select_command_rx.sv
/* bench: commands through the host model and the local port
   assumes the 40 MHz clock of the package */
module test_serial_port_select_command_rx;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic rx_serial;
  logic sel_req = 1'b0;
  logic [4:0] sel_channel = 5'h00;
  logic tx_serial;
  logic [4:0] channel;
  logic video_on;
  int n_errors = 0;
  int tests_run = 0;
  // clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  serial_port_select u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .rx_serial(rx_serial), .sel_req(sel_req), .sel_channel(sel_channel),
    .tx_serial(tx_serial), .channel(channel), .video_on(video_on));
  serial_host u_host (.clk_sys(clk_sys), .line_in(tx_serial),
    .line_out(rx_serial));
  task automatic check(input string s, input logic [7:0] v, e);
    tests_run++;
    n_errors += int'(v !== e);
    if (v !== e)
      $display("MISMATCH %s exp %h seen %h", s, e, v);
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // hang guard counted in clock cycles
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
  task automatic rx_select;
    u_host.send(8'h10);
    check("chan", {3'h0, channel}, 8'h01);
    check("video_sel", {7'h0, video_on}, 8'h01);
  endtask : rx_select
  task automatic local_select;
    @(negedge clk_sys);
    sel_req = 1'b1;
    sel_channel = 5'h10;
    @(negedge clk_sys);
    sel_channel = 5'h11;
    @(negedge clk_sys);
    sel_req = 1'b0;
    check("local", {3'h0, channel}, 8'h10);
  endtask : local_select
  task automatic rx_invalid;
    u_host.send(8'h0f);
    check("invalid", {3'h0, channel}, 8'h10);
  endtask : rx_invalid
  task automatic rx_off;
    u_host.send(8'h71);
    check("off", {3'h0, channel}, 8'h00);
    check("video", {7'h0, video_on}, 8'h00);
  endtask : rx_off
  task automatic echo_order;
    for (int i = 0; i < 30000 && u_host.got.size() < 3; i++)
      @(posedge clk_sys);
    check("count", 8'(u_host.got.size()), 8'h03);
    check("echo0", u_host.got[0], 8'h10);
    check("code", u_host.got[1], 8'h1f);
    check("echo1", u_host.got[2], 8'h71);
  endtask : echo_order
  // reset for 12 cycles, then the scenarios
  initial
  begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    rx_select();
    local_select();
    rx_invalid();
    rx_off();
    echo_order();
    finish_test();
  end
endmodule : test_serial_port_select_command_rx
